// >>> core/smr_filt.sv
`timescale 1ns/100ps
`default_nettype none

module smr_filt #(
	parameter int unsigned N       = 2,
	parameter logic [1:0]  RST_VAL = 2'b11
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// raw pins and filtered levels
	input  wire logic [N-1:0] raw,
	output var  logic [N-1:0] filt
);

	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_line
			logic s1_ff;
			logic s2_ff;
			logic s3_ff;
			// a level is taken only once two stages agree
			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					s1_ff   <= RST_VAL[i];
					s2_ff   <= RST_VAL[i];
					s3_ff   <= RST_VAL[i];
					filt[i] <= RST_VAL[i];
				end
				else
				begin
					s1_ff <= raw[i];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					if (s2_ff == s3_ff)
						filt[i] <= s3_ff;
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// >>> core/smr_map.svh
`ifndef SMR_MAP_SVH
`define SMR_MAP_SVH

// slave address: fixed prefix plus strap-selected low bits
`define SMR_ADDR_PREFIX   5'b01011
`define SMR_SEL_HIGH      2'b01
`define SMR_SEL_MID       2'b10
`define SMR_SEL_LOW       2'b00

// register space and pointer limits
`define SMR_REG_LAST      8'hef
`define SMR_PTR_MAX       8'hff
`define SMR_RD_ZERO       8'h00

// block command codes
`define SMR_CMD_BLKWR     8'hf0
`define SMR_CMD_PROC      8'hf1
`define SMR_CMD_FIX_FIRST 8'hf2
`define SMR_CMD_FIX_LAST  8'hfd

// fixed block table, {start, size}, code fdh in the top entry
`define SMR_FIX_TABLE {16'he509, 16'hd010, 16'hc808, 16'hb408, \
	16'h9020, 16'h780c, 16'h6e08, 16'h6704, \
	16'h5610, 16'h5006, 16'h4808, 16'h4008}

// byte framing
`define SMR_BIT_LAST      4'd7
`define SMR_BIT_FULL      4'd8
`define SMR_BIT_ZERO      4'd0
`define SMR_IDX_CMD       2'd0
`define SMR_IDX_CNT       2'd1
`define SMR_IDX_START     2'd2
`define SMR_IDX_MORE      2'd3

// bus-low timeout
`define SMR_CLK_MHZ       50
`define SMR_TIMEOUT_US    25000
`define SMR_TIMEOUT_CYC   (`SMR_TIMEOUT_US * `SMR_CLK_MHZ)

`endif

// >>> core/smr_pkg.sv
package smr_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_ACK_TX,
		ST_TX,
		ST_ACK_RX,
		ST_SKIP
	} smr_state_e;

	typedef enum logic [1:0] {
		MD_PTR,
		MD_BLKWR,
		MD_PROC,
		MD_FIXED
	} smr_mode_e;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} smr_req_s;

endpackage

// >>> core/smr_port.sv
// Functional notes
// - first prefix match after power-up latches the strapped address for good
// - select high gives low bits 01, mid 10, low 00; prefix 01011
// - clock and data lines are filtered before the protocol logic sees them
// - start is data falling while clock high; next eight bits are the address
// - address byte is seven bits msb first, then direction, one meaning read
// - on a match drive the ninth-bit acknowledge low; ignore other addresses
// - nine clocks per byte; data moves only while the clock is low, except that an abort releases it at once, even with the clock high
// - first written byte after the address is a command or a pointer
// - host ends a read by not acknowledging; device then releases data
// - either line low past the timeout returns the machine to idle
// - the external reset pin does not touch the serial machine
// - every start reinitialises the serial machine
// - a start or stop inside a written byte discards that byte
// - a start or stop inside a read byte leaves clear-on-read registers
// - registers sit at 00h to efh; codes f0h to fdh are block commands, feh and ffh act as pointers
// - only send, write, block write, reads and process call; no pec or ara
// - the base pointer does not advance after reads, except process call
// - command f0h starts a block write
// - command f1h starts a block write then block read process call
// - codes f2h to fdh select fixed block reads from a table
// - write byte: pointer then data, each acknowledged, data stored
// - block write ignores the count; next byte is the start register
// - out-of-range writes acknowledged and dropped; pointer stops at ffh
// - out-of-range reads return 00h; reads go on while acknowledged
`include "smr_map.svh"
`timescale 1ns/100ps
`default_nettype none

module smr_port #(
	parameter int unsigned TIMEOUT_CYC = `SMR_TIMEOUT_CYC
) (
	// clock and power-on reset
	input  wire logic              CLOCK,
	input  wire logic              RST_B,
	// two-wire bus pins
	input  wire logic              SCL_IN,
	input  wire logic              SDA_IN,
	output var  logic              SDA_OUT,
	output var  logic              SDA_OE,
	// three-level address select from the pin comparators
	input  wire logic              ADDR_SEL_HIGH,
	input  wire logic              ADDR_SEL_MID,
	// register file side
	output var  smr_pkg::smr_req_s REG_REQ,
	input  wire logic [7:0]        REG_RDATA
);

	logic [1:0] bus_f;
	logic [1:0] sel_f;
	logic       tmo;

	smr_pkg::smr_state_e state_ff;
	smr_pkg::smr_mode_e  mode_ff;

	logic       scl_d_ff;
	logic       sda_d_ff;
	logic [3:0] bit_ff;
	logic [7:0] shift_ff;
	logic [7:0] tx_ff;
	logic       in_addr_ff;
	logic       rw_ff;
	logic [1:0] idx_ff;
	logic       lat_ok_ff;
	logic [1:0] lat_ff;
	logic [7:0] base_ff;
	logic [7:0] work_ff;
	logic [7:0] cnt_ff;
	logic       cnt_pend_ff;
	logic       mack_ff;

	// filtered lines, power-on reset only; no other reset reaches here
	smr_filt #(
		.N       (2),
		.RST_VAL (2'b11)
	) u_bus_filt (
		.clk   (CLOCK),
		.rst_b (RST_B),
		.raw   ({SCL_IN, SDA_IN}),
		.filt  (bus_f)
	);

	smr_filt #(
		.N       (2),
		.RST_VAL (2'b00)
	) u_sel_filt (
		.clk   (CLOCK),
		.rst_b (RST_B),
		.raw   ({ADDR_SEL_HIGH, ADDR_SEL_MID}),
		.filt  (sel_f)
	);

	wire scl = bus_f[1];
	wire sda = bus_f[0];

	// stuck-low watchdog on either line
	smr_tmo #(
		.LIMIT (TIMEOUT_CYC)
	) u_tmo (
		.clk    (CLOCK),
		.rst_b  (RST_B),
		.low    (~scl | ~sda),
		.expire (tmo)
	);

	// bus events
	wire scl_rise  = scl & ~scl_d_ff;
	wire scl_fall  = ~scl & scl_d_ff;
	wire start_det = scl & scl_d_ff & sda_d_ff & ~sda;
	wire stop_det  = scl & scl_d_ff & ~sda_d_ff & sda;

	// strap decode
	wire [1:0] sel_code = sel_f[1] ? `SMR_SEL_HIGH :
		sel_f[0] ? `SMR_SEL_MID : `SMR_SEL_LOW;

	// address match, latched low bits win once captured
	wire pfx_hit  = (shift_ff[7:3] == `SMR_ADDR_PREFIX);
	wire [1:0] own_low = lat_ok_ff ? lat_ff : sel_code;
	wire addr_hit = pfx_hit & (shift_ff[2:1] == own_low);

	// a byte is whole only at the falling edge after its eighth bit
	wire byte_done = (state_ff == smr_pkg::ST_RX) & scl_fall &
		(bit_ff == `SMR_BIT_FULL);
	wire addr_done = byte_done & in_addr_ff;
	wire data_done = byte_done & ~in_addr_ff;

	// command decode
	wire is_blkwr = (shift_ff == `SMR_CMD_BLKWR);
	wire is_proc  = (shift_ff == `SMR_CMD_PROC);
	wire is_fix   = (shift_ff >= `SMR_CMD_FIX_FIRST) &
		(shift_ff <= `SMR_CMD_FIX_LAST);
	wire [3:0]   fix_idx = 4'(shift_ff - `SMR_CMD_FIX_FIRST);
	wire [191:0] fix_tab = `SMR_FIX_TABLE;
	wire [15:0]  fix_ent = fix_tab[{fix_idx, 4'h0} +: 16];
	wire is_cmd   = data_done & (idx_ff == `SMR_IDX_CMD);

	// data-byte slots per mode
	wire ptr_data = (mode_ff == smr_pkg::MD_PTR) &
		(idx_ff != `SMR_IDX_CMD);
	wire blk_data = (mode_ff == smr_pkg::MD_BLKWR) &
		(idx_ff == `SMR_IDX_MORE);
	wire wr_slot  = data_done & (ptr_data | blk_data);
	wire set_start = data_done & (idx_ff == `SMR_IDX_START) &
		((mode_ff == smr_pkg::MD_BLKWR) | (mode_ff == smr_pkg::MD_PROC));
	wire set_cnt  = data_done & (idx_ff == `SMR_IDX_MORE) &
		(mode_ff == smr_pkg::MD_PROC);

	// range and saturating pointer step
	wire in_range = (work_ff <= `SMR_REG_LAST);
	wire [7:0] nxt_work = (work_ff == `SMR_PTR_MAX) ? work_ff :
		8'(work_ff + 8'h01);

	// block reads open with the count byte
	wire blk_rd  = (mode_ff == smr_pkg::MD_PROC) |
		(mode_ff == smr_pkg::MD_FIXED);
	wire cnt_out = blk_rd & cnt_pend_ff;
	wire [7:0] rd_byte = cnt_out ? cnt_ff :
		(in_range ? REG_RDATA : `SMR_RD_ZERO);

	// transmit progress; clear-on-read only after all eight bits
	wire tx_fall  = (state_ff == smr_pkg::ST_TX) & scl_fall;
	wire tx_last  = tx_fall & (bit_ff == `SMR_BIT_LAST);
	wire ack_fall = (state_ff == smr_pkg::ST_ACK_TX) & scl_fall;
	wire go_tx    = ack_fall & rw_ff & in_addr_ff;
	wire mack_fall = (state_ff == smr_pkg::ST_ACK_RX) & scl_fall;
	wire tx_next  = go_tx | (mack_fall & mack_ff);
	wire abort    = start_det | stop_det | tmo;

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end
		else
		begin
			scl_d_ff <= scl;
			sda_d_ff <= sda;
		end
	end

	// protocol state; start reinitialises from anywhere
	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
			state_ff <= smr_pkg::ST_IDLE;
		else if (start_det)
			state_ff <= smr_pkg::ST_RX;
		else if (stop_det || tmo)
			state_ff <= smr_pkg::ST_IDLE;
		else if (addr_done && !addr_hit)
			state_ff <= smr_pkg::ST_SKIP;
		else if (byte_done)
			state_ff <= smr_pkg::ST_ACK_TX;
		else if (tx_next)
			state_ff <= smr_pkg::ST_TX;
		else if (ack_fall)
			state_ff <= smr_pkg::ST_RX;
		else if (tx_last)
			state_ff <= smr_pkg::ST_ACK_RX;
		else if (mack_fall)
			state_ff <= smr_pkg::ST_SKIP;
	end

	// bit counter and shifters, msb first
	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			bit_ff   <= `SMR_BIT_ZERO;
			shift_ff <= 8'h00;
			tx_ff    <= 8'h00;
		end
		else if (abort || ack_fall || tx_next)
		begin
			bit_ff <= `SMR_BIT_ZERO;
			if (tx_next)
				tx_ff <= rd_byte;
		end
		else if (state_ff == smr_pkg::ST_RX && scl_rise)
		begin
			bit_ff   <= bit_ff + 4'd1;
			shift_ff <= {shift_ff[6:0], sda};
		end
		else if (tx_fall)
		begin
			bit_ff <= bit_ff + 4'd1;
			tx_ff  <= {tx_ff[6:0], 1'b0};
		end
	end

	// data line: ack, then read bits, changed on falling clock or released at once on abort
	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
			SDA_OE <= 1'b0;
		else if (abort || tx_last || ack_fall)
			SDA_OE <= !abort && tx_next && !rd_byte[7];
		else if (addr_done)
			SDA_OE <= addr_hit;
		else if (data_done)
			SDA_OE <= 1'b1;
		else if (tx_next)
			SDA_OE <= ~rd_byte[7];
		else if (tx_fall)
			SDA_OE <= ~tx_ff[6];
		else if (mack_fall)
			SDA_OE <= 1'b0;
	end

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
			SDA_OUT <= 1'b0;
		else
			SDA_OUT <= 1'b0;
	end

	// master acknowledge sampled on the ninth rising clock
	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
			mack_ff <= 1'b0;
		else if (state_ff == smr_pkg::ST_ACK_RX && scl_rise)
			mack_ff <= ~sda;
	end

	// transaction framing
	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			in_addr_ff <= 1'b0;
			rw_ff      <= 1'b0;
			idx_ff     <= `SMR_IDX_CMD;
		end
		else if (start_det)
		begin
			in_addr_ff <= 1'b1;
			idx_ff     <= `SMR_IDX_CMD;
		end
		else if (addr_done)
			rw_ff <= shift_ff[0];
		else if (ack_fall)
			in_addr_ff <= 1'b0;
		else if (data_done && idx_ff != `SMR_IDX_MORE)
			idx_ff <= idx_ff + 2'd1;
	end

	// address capture, held until power is removed
	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			lat_ok_ff <= 1'b0;
			lat_ff    <= `SMR_SEL_LOW;
		end
		else if (addr_done && pfx_hit && !lat_ok_ff)
		begin
			lat_ok_ff <= 1'b1;
			lat_ff    <= sel_code;
		end
	end

	// command, mode and base pointer
	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			mode_ff <= smr_pkg::MD_PTR;
			base_ff <= 8'h00;
			cnt_ff  <= 8'h00;
		end
		else if (is_cmd)
		begin
			if (is_blkwr)
				mode_ff <= smr_pkg::MD_BLKWR;
			else if (is_proc)
				mode_ff <= smr_pkg::MD_PROC;
			else if (is_fix)
			begin
				mode_ff <= smr_pkg::MD_FIXED;
				base_ff <= fix_ent[15:8];
				cnt_ff  <= fix_ent[7:0];
			end
			else
			begin
				mode_ff <= smr_pkg::MD_PTR;
				base_ff <= shift_ff;
			end
		end
		else if (set_start)
			base_ff <= shift_ff;
		else if (set_cnt)
			cnt_ff <= shift_ff;
		else if (tx_last && !cnt_out && mode_ff == smr_pkg::MD_PROC)
			base_ff <= nxt_work;
	end

	// working pointer; reloaded from base at every read address
	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
			work_ff <= 8'h00;
		else if (is_cmd && !is_blkwr && !is_proc)
			work_ff <= is_fix ? fix_ent[15:8] : shift_ff;
		else if (set_start)
			work_ff <= shift_ff;
		else if (addr_done && addr_hit && shift_ff[0])
			work_ff <= base_ff;
		else if (wr_slot || (tx_last && !cnt_out))
			work_ff <= nxt_work;
	end

	// count byte goes first in a block read
	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
			cnt_pend_ff <= 1'b0;
		else if (addr_done)
			cnt_pend_ff <= shift_ff[0];
		else if (tx_last)
			cnt_pend_ff <= 1'b0;
	end

	// register file strobes; only whole bytes commit
	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
			REG_REQ <= '0;
		else
		begin
			REG_REQ.wr    <= wr_slot & in_range;
			REG_REQ.rd    <= tx_last & ~cnt_out & in_range;
			REG_REQ.addr  <= work_ff;
			REG_REQ.wdata <= shift_ff;
		end
	end

endmodule

`default_nettype wire

// >>> core/smr_tmo.sv
`timescale 1ns/100ps
`default_nettype none

module smr_tmo #(
	parameter int unsigned LIMIT = 1250000
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// either bus line low, and timeout pulse
	input  wire logic low,
	output var  logic expire
);

	localparam int unsigned W = $clog2(LIMIT + 1);
	localparam logic [W-1:0] LAST = W'(LIMIT - 1);

	logic [W-1:0] cnt_ff;

	wire at_last = (cnt_ff == LAST);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_ff <= '0;
			expire <= 1'b0;
		end
		else
		begin
			expire <= low & at_last;
			if (!low || at_last)
				cnt_ff <= '0;
			else
				cnt_ff <= cnt_ff + 1'b1;
		end
	end

endmodule

`default_nettype wire

// >>> dv/smr_host.sv
`timescale 1ns/100ps
`default_nettype none

module smr_host (
	// device drive of the data line
	input  wire logic dev_oe,
	input  wire logic dev_out,
	// wired bus levels with pull-ups
	output var  logic scl,
	output wire logic sda
);
	logic hold_low;

	initial
	begin
		scl = 1'b1;
		hold_low = 1'b0;
	end
	assign sda = !(hold_low || (dev_oe && !dev_out));

	// one bit: data set early in the low phase, sampled late in high
	task bit_io(input logic v, output logic s);
		#20 hold_low = !v;
		#80 scl = 1'b1;
		#40 s = sda;
		#20 scl = 1'b0;
	endtask
	task start;
		#20 hold_low = 1'b0;
		#80 scl = 1'b1;
		#40 hold_low = 1'b1;
		#40 scl = 1'b0;
	endtask
	task stop;
		#20 hold_low = 1'b1;
		#80 scl = 1'b1;
		#40 hold_low = 1'b0;
		#40;
	endtask
	task wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask
	task rbyte(output logic [7:0] b, input logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, b[i]);
		bit_io(!ack, s);
	endtask
endmodule

`default_nettype wire

// >>> dv/smr_port_chk.sv
`timescale 1ns/100ps
`default_nettype none

module smr_port_chk #(
	parameter int unsigned TIMEOUT_CYC = 1250000
) (
	// clock and reset
	input wire logic              CLOCK,
	input wire logic              RST_B,
	// bus pins
	input wire logic              SCL_IN,
	input wire logic              SDA_IN,
	input wire logic              SDA_OUT,
	input wire logic              SDA_OE,
	// register side
	input wire smr_pkg::smr_req_s REG_REQ
);
	int unsigned low_cnt;

	// raw cycles with either line low, saturating
	always_ff @(posedge CLOCK or negedge RST_B)
		if (!RST_B)
			low_cnt <= 0;
		else if (SCL_IN && SDA_IN)
			low_cnt <= 0;
		else if (low_cnt < TIMEOUT_CYC + 16)
			low_cnt <= low_cnt + 1;

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);

	property p_od;
		SDA_OUT == 1'b0;
	endproperty
	a_od: assert property (p_od)
		else $error("data pin driven high");
	property p_oe_low;
		$changed(SDA_OE) |-> !$past(SCL_IN) || !$past(SCL_IN, 2) ||
			!$past(SCL_IN, 3) || !$past(SCL_IN, 4);
	endproperty
	a_oe_low: assert property (p_oe_low)
		else $error("data moved with clock high");
	property p_hi;
		SCL_IN [*2] |-> $stable(SDA_OE);
	endproperty
	a_hi: assert property (p_hi)
		else $error("data drive changed in high phase");
	property p_wr_pulse;
		REG_REQ.wr |=> !REG_REQ.wr;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse)
		else $error("write strobe longer than one cycle");
	property p_wr_ack;
		REG_REQ.wr |-> SDA_OE;
	endproperty
	a_wr_ack: assert property (p_wr_ack)
		else $error("byte stored without acknowledge");
	property p_wr_range;
		REG_REQ.wr |-> REG_REQ.addr <= 8'hef;
	endproperty
	a_wr_range: assert property (p_wr_range)
		else $error("store outside register space");
	property p_rd_rel;
		REG_REQ.rd |-> !SDA_OE ##1 !REG_REQ.rd;
	endproperty
	a_rd_rel: assert property (p_rd_rel)
		else $error("read strobe without release");
	property p_tmo;
		low_cnt > TIMEOUT_CYC + 8 |-> !SDA_OE;
	endproperty
	a_tmo: assert property (p_tmo)
		else $error("data held past bus timeout");
endmodule

bind smr_port smr_port_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.CLOCK,
	.RST_B, .SCL_IN, .SDA_IN, .SDA_OUT, .SDA_OE, .REG_REQ);

`default_nettype wire

// >>> dv/smr_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module smr_port_tb_top;
	localparam int unsigned TMO = 400;
	logic              clock, rst_b, sel_high, sel_mid, k;
	wire logic         sda_oe, sda_out, scl, sda;
	wire logic [7:0]   rdata;
	smr_pkg::smr_req_s req;
	logic [7:0]        mem [256];
	logic [7:0]        em [256];
	logic [7:0]        b;
	logic [6:0]        adr;
	int                n_mismatch, cmp_count, i, j, n, p, d;
	int fst [12] = '{8'h40, 8'h48, 8'h50, 8'h56, 8'h67, 8'h6e, 8'h78,
		8'h90, 8'hb4, 8'hc8, 8'hd0, 8'he5};
	int fsz [12] = '{8, 8, 6, 16, 4, 8, 12, 32, 8, 8, 16, 9};

	smr_port #(.TIMEOUT_CYC(TMO)) dut (.CLOCK(clock), .RST_B(rst_b),
		.SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.ADDR_SEL_HIGH(sel_high), .ADDR_SEL_MID(sel_mid),
		.REG_REQ(req), .REG_RDATA(rdata));
	smr_host host (.dev_oe(sda_oe), .dev_out(sda_out), .scl(scl),
		.sda(sda));

	// register file beside the port
	assign rdata = mem[req.addr];
	always @(posedge clock)
		if (req.wr === 1'b1)
			mem[req.addr] <= req.wdata;

	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	function automatic logic [7:0] exp_rd(input int a);
		return (a > 8'hef) ? 8'h00 : em[a];
	endfunction
	function automatic logic [6:0] addr_of(input logic h, input logic m);
		return {5'b01011, h ? 2'b01 : (m ? 2'b10 : 2'b00)};
	endfunction

	task chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// stay 7 ns after a clock edge so bus edges never meet it
	task cyc(input int c);
		repeat (c) @(posedge clock);
		#7;
	endtask
	task put(input logic [7:0] v, input logic e);
		host.wbyte(v, k);
		chk({7'h0, k}, {7'h0, e});
	endtask
	task get(input logic [7:0] e, input logic a);
		host.rbyte(b, a);
		chk(b, e);
	endtask
	task sa(input logic r);
		host.start();
		put({adr, r}, 1'b1);
	endtask
	task wr1(input logic [7:0] pp, input logic [7:0] dd);
		sa(1'b0);
		put(pp, 1'b1);
		put(dd, 1'b1);
		host.stop();
		if (pp <= 8'hef)
			em[pp] = dd;
	endtask
	task print_verdict;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		#1500000;
		n_mismatch++;
		print_verdict();
	end

	initial
	begin
		d = $urandom(32'h807c9ae3);
		rst_b = 1'b0;
		n_mismatch = 0;
		cmp_count = 0;
		for (i = 0; i < 256; i++)
			mem[i] = 8'($urandom);
		em = mem;
		d = $urandom % 3;
		sel_high = (d == 0);
		sel_mid = (d == 1);
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		cyc(4);
		adr = addr_of(sel_high, sel_mid);
		host.start();
		put({5'b11011, adr[1:0], 1'b0}, 1'b0);
		host.start();
		put({adr ^ 7'h03, 1'b0}, 1'b0);
		host.stop();
		for (i = 0; i < 4; i++)
			wr1(8'($urandom_range(239)), 8'($urandom));
		@(posedge clock);
		sel_high <= ~sel_high;
		sel_mid <= ~sel_mid;
		cyc(4);
		wr1(8'($urandom_range(239)), 8'($urandom));
		host.start();
		put({addr_of(sel_high, sel_mid), 1'b0}, 1'b0);
		host.stop();
		// pointer, then two reads without a new pointer
		p = $urandom_range(238);
		sa(1'b0);
		put(8'(p), 1'b1);
		sa(1'b1);
		get(exp_rd(p), 1'b1);
		get(exp_rd(p + 1), 1'b0);
		host.stop();
		sa(1'b1);
		get(exp_rd(p), 1'b0);
		host.stop();
		// block write running off the top of the map
		sa(1'b0);
		put(8'hf0, 1'b1);
		put(8'h01, 1'b1);
		put(8'hee, 1'b1);
		for (i = 0; i < 4; i++)
		begin
			d = $urandom_range(255, 1);
			put(8'(d), 1'b1);
			if (i < 2)
				em[8'hee + i] = 8'(d);
		end
		host.stop();
		for (i = 0; i < 12; i++)
		begin
			sa(1'b0);
			put(8'(8'hf2 + i), 1'b1);
			sa(1'b1);
			get(8'(fsz[i]), 1'b1);
			n = (i == 11) ? 12 : 2;
			for (j = 0; j < n; j++)
				get(exp_rd(fst[i] + j), j < n - 1);
			host.stop();
		end
		p = $urandom_range(8'h80);
		sa(1'b0);
		put(8'hf1, 1'b1);
		put(8'h02, 1'b1);
		put(8'(p), 1'b1);
		put(8'h03, 1'b1);
		sa(1'b1);
		get(8'h03, 1'b1);
		for (j = 0; j < 3; j++)
			get(exp_rd(p + j), j < 2);
		host.stop();
		// process call moved the base: a plain reread goes on from there
		sa(1'b1);
		get(8'h03, 1'b1);
		get(exp_rd(p + 3), 1'b0);
		host.stop();
		// start inside a data byte
		p = $urandom_range(239);
		sa(1'b0);
		put(8'(p), 1'b1);
		for (j = 0; j < 4; j++)
			host.bit_io(~em[p][j], k);
		sa(1'b0);
		host.stop();
		// clock stuck low while the device drives a zero
		wr1(8'(p), 8'h3c);
		sa(1'b0);
		put(8'(p), 1'b1);
		sa(1'b1);
		host.bit_io(1'b1, k);
		cyc(TMO + 20);
		chk({7'h0, sda_oe}, 8'h00);
		wr1(8'($urandom_range(239)), 8'($urandom));
		cyc(2);
		for (i = 0; i < 240; i++)
			chk(mem[i], em[i]);
		print_verdict();
	end
endmodule

`default_nettype wire
